// *** design/fsp_core_end.sv ***
// Core end: takes orders over a classic Wishbone slave, drives the
// control write and store operation, and stalls while halted.
// Assumes a single Wishbone master on the same clock.
`timescale 1ns/10ps
module fsp_core_end
(
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       ce_i,
   fsp_if.core                             link,
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [fsp_pkg::ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [31:0]                wb_dat_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o
);
   typedef enum logic [3:0]
   {
      HS_IDLE  = 4'b0001,
      HS_CTRL  = 4'b0010,
      HS_STORE = 4'b0100,
      HS_WAIT  = 4'b1000
   } fsp_hstate_t;

   fsp_hstate_t                 hs_q;
   fsp_hstate_t                 hs_d;
   logic [fsp_pkg::PTR_W-1:0]   ptr_q;
   logic [fsp_pkg::PTR_W-1:0]   ptr_d;
   logic [fsp_pkg::DATA_W-1:0]  data_q;
   logic [fsp_pkg::DATA_W-1:0]  data_d;
   logic [8:0]                  cmd_q;
   logic [8:0]                  cmd_d;
   logic                        ack_d;
   logic [31:0]                 rdat_d;
   logic                        ee_q;
   logic                        ee_d;
   logic                        wr_go;
   logic                        busy;

   // Write strobe of one register, any byte lanes
   function automatic logic hit(input logic [fsp_pkg::ADR_W-1:0] a);
      hit = wr_go && (wb_adr_i == a);
   endfunction : hit

   assign busy  = (hs_q != HS_IDLE) || link.halt;
   assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !link.halt;

   ////////////////////////////////////////////////////////////////////////////
   // Bus and command next state
   always_comb
   begin
      hs_d   = hs_q;
      ptr_d  = ptr_q;
      data_d = data_q;
      cmd_d  = cmd_q;
      ee_d   = 1'b0;
      ack_d  = wb_cyc_i && wb_stb_i && !wb_ack_o && !link.halt;  // Halt stalls bus
      rdat_d = '0;
      unique case (wb_adr_i)
         fsp_pkg::ADR_PTR:    rdat_d = {16'h0, ptr_q};
         fsp_pkg::ADR_DATA:   rdat_d = {16'h0, data_q};
         fsp_pkg::ADR_CMD:    rdat_d = {23'h0, cmd_q};
         fsp_pkg::ADR_STATUS: rdat_d = {16'h0, link.ctrl_rdata, 7'h0, busy};
         default:             rdat_d = '0;
      endcase
      if (hit(fsp_pkg::ADR_PTR))
      begin
         if (wb_sel_i[0]) ptr_d[7:0]  = wb_dat_i[7:0];
         if (wb_sel_i[1]) ptr_d[15:8] = wb_dat_i[15:8];
      end
      if (hit(fsp_pkg::ADR_DATA))
      begin
         if (wb_sel_i[0]) data_d[7:0]  = wb_dat_i[7:0];
         if (wb_sel_i[1]) data_d[15:8] = wb_dat_i[15:8];
      end
      if (hit(fsp_pkg::ADR_EEWR))
      begin
         ee_d = 1'b1;
      end
      unique case (hs_q)
         HS_IDLE:
         begin
            if (hit(fsp_pkg::ADR_CMD) && (&wb_sel_i[1:0]))
            begin
               cmd_d = wb_dat_i[8:0];
               hs_d  = HS_CTRL;
            end
         end
         HS_CTRL:  hs_d = cmd_q[fsp_pkg::CMD_NOSTORE] ? HS_IDLE : HS_STORE;
         HS_STORE: hs_d = HS_WAIT;
         HS_WAIT:
         begin
            if (!link.halt)
            begin
               hs_d = HS_IDLE;
            end
         end
         default:  hs_d = HS_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         hs_q     <= HS_IDLE;
         ptr_q    <= '0;
         data_q   <= '0;
         cmd_q    <= '0;
         ee_q     <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end
      else if (ce_i)
      begin
         hs_q     <= hs_d;
         ptr_q    <= ptr_d;
         data_q   <= data_d;
         cmd_q    <= cmd_d;
         ee_q     <= ee_d;
         wb_ack_o <= ack_d;
         wb_dat_o <= rdat_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link drive; pointer and data as software set them
   assign link.ctrl_we    = (hs_q == HS_CTRL);
   assign link.ctrl_wdata = {2'h0, cmd_q[5:0]};
   assign link.store_op   = (hs_q == HS_STORE);     // One cycle after control write
   assign link.ptr        = ptr_q;
   assign link.data_word  = data_q;
   assign link.eeprom_wr  = ee_q;
endmodule : fsp_core_end

// *** design/fsp_if.sv ***
// Link between the core end and the self-program sequencer.
// Assumes both ends on the same clock; all signals are plain levels or pulses.
`timescale 1ns/10ps
interface fsp_if;
   logic                        ctrl_we;     // Control register write strobe
   logic [fsp_pkg::CTRL_W-1:0]  ctrl_wdata;  // Control register write value
   logic [fsp_pkg::CTRL_W-1:0]  ctrl_rdata;  // Control register readback
   logic                        store_op;    // Store-program operation pulse
   logic [fsp_pkg::PTR_W-1:0]   ptr;         // Address pointer
   logic [fsp_pkg::DATA_W-1:0]  data_word;   // Data word pair
   logic                        eeprom_wr;   // EEPROM write event pulse
   logic                        halt;        // Core halt request

   modport dev  (input ctrl_we, ctrl_wdata, store_op, ptr, data_word, eeprom_wr,
                 output ctrl_rdata, halt);
   modport core (output ctrl_we, ctrl_wdata, store_op, ptr, data_word, eeprom_wr,
                 input ctrl_rdata, halt);
endinterface : fsp_if

// *** design/fsp_page_buf.sv ***
// Temporary page buffer: one word per write, random order, bulk clear.
// Assumes clear has priority over a write in the same cycle.
`timescale 1ns/10ps
module fsp_page_buf
(
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic                         ce_i,
   input  wire logic                         clr_i,
   input  wire logic                         we_i,
   input  wire logic [fsp_pkg::WORD_W-1:0]   widx_i,
   input  wire logic [fsp_pkg::DATA_W-1:0]   wdata_i,
   input  wire logic [fsp_pkg::WORD_W-1:0]   ridx_i,
   output logic      [fsp_pkg::DATA_W-1:0]   rdata_o,
   output logic                              any_loaded_o
);
   logic [fsp_pkg::DATA_W-1:0]     mem_q [fsp_pkg::PAGE_WORDS];
   logic [fsp_pkg::DATA_W-1:0]     mem_d [fsp_pkg::PAGE_WORDS];
   logic [fsp_pkg::PAGE_WORDS-1:0] used_q;
   logic [fsp_pkg::PAGE_WORDS-1:0] used_d;
   logic [fsp_pkg::DATA_W-1:0]     rdata_d;

   ////////////////////////////////////////////////////////////////////////////
   // Next contents
   always_comb
   begin
      mem_d  = mem_q;
      used_d = used_q;
      if (clr_i)
      begin
         for (int i = 0; i < fsp_pkg::PAGE_WORDS; i++)
         begin
            mem_d[i] = fsp_pkg::ERASED_WORD;
         end
         used_d = '0;
      end
      else if (we_i)
      begin
         mem_d[widx_i]  = wdata_i;  // Any position, any order
         used_d[widx_i] = 1'b1;
      end
      rdata_d = mem_q[ridx_i];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < fsp_pkg::PAGE_WORDS; i++)
         begin
            mem_q[i] <= fsp_pkg::ERASED_WORD;
         end
         used_q  <= '0;
         rdata_o <= fsp_pkg::ERASED_WORD;
      end
      else if (ce_i)
      begin
         mem_q   <= mem_d;
         used_q  <= used_d;
         rdata_o <= rdata_d;
      end
   end

   assign any_loaded_o = |used_q;
endmodule : fsp_page_buf

// *** design/fsp_pkg.sv ***
// Shared constants for the flash self-program sequencer and its core end.
// Assumes one system clock for both ends and the flash array.
package fsp_pkg;
   // Pointer and data geometry
   localparam int PTR_W      = 16;
   localparam int DATA_W     = 16;
   localparam int WORD_W     = 6;
   localparam int PAGE_W     = 7;
   localparam int PAGE_WORDS = 64;
   localparam int WORD_LSB   = 1;
   localparam int PAGE_LSB   = 7;
   localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;

   // Control register bits
   localparam int CTRL_W   = 8;
   localparam int BIT_EN   = 0;
   localparam int BIT_ERS  = 1;
   localparam int BIT_WRT  = 2;
   localparam int BIT_CLR  = 4;
   localparam logic [5:0] CODE_MASK = 6'h3f;

   // Command codes in the low six control bits
   localparam logic [5:0] CODE_LOAD  = 6'h01;
   localparam logic [5:0] CODE_ERASE = 6'h03;
   localparam logic [5:0] CODE_WRITE = 6'h05;
   localparam logic [5:0] CODE_CLEAR = 6'h11;

   // Store window after a control write, in clock cycles
   localparam logic [2:0] ARM_CYCLES = 3'h4;

   // Core end register map (byte addresses)
   localparam int ADR_W = 8;
   localparam logic [ADR_W-1:0] ADR_PTR    = 8'h00;
   localparam logic [ADR_W-1:0] ADR_DATA   = 8'h04;
   localparam logic [ADR_W-1:0] ADR_CMD    = 8'h08;
   localparam logic [ADR_W-1:0] ADR_STATUS = 8'h0c;
   localparam logic [ADR_W-1:0] ADR_EEWR   = 8'h10;
   localparam int CMD_NOSTORE = 8;
   localparam int STAT_BUSY   = 0;
   localparam int STAT_CTRL   = 8;
endpackage : fsp_pkg

// *** design/fsp_seq_dev.sv ***
// Self-program sequencer: control register, store window, page buffer,
// erase and write requests to the flash array, core halt.
// Assumes the flash array reports completion with a one-cycle done pulse
// on the same clock and reads the buffer through its own index port.
//
// Functional notes
// - Erase page before writing it from buffer
// - One word per store; fill any phase
// - Buffer positions load in any order
// - Software uses same page for erase/write
// - Code 03 plus store erases page
// - Erase page chosen by page field only
// - Core halted for whole page erase
// - Code 01 plus store loads data word
// - Word field selects buffer location
// - Buffer clears on write, clear, reset
// - Software loads each location once
// - EEPROM write during loading loses buffer
// - Code 05 plus store writes page
// - Software zeroes non-page pointer bits for write
// - Core halted for whole page write
// - Bits clear after four idle cycles
// - Enable stays set until erase/write ends
// - Undefined codes have no effect
// - Pointer bit zero ignored on load
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
module fsp_seq_dev
(
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic                         ce_i,
   fsp_if.dev                                link,
   output logic                              flash_erase_o,
   output logic                              flash_write_o,
   output logic      [fsp_pkg::PAGE_W-1:0]   flash_page_o,
   input  wire logic                         flash_done_i,
   input  wire logic [fsp_pkg::WORD_W-1:0]   flash_rd_idx_i,
   output logic      [fsp_pkg::DATA_W-1:0]   flash_rd_data_o
);
   typedef enum logic [3:0]
   {
      ST_IDLE  = 4'b0001,
      ST_ARMED = 4'b0010,
      ST_ERASE = 4'b0100,
      ST_WRITE = 4'b1000
   } fsp_state_t;

   fsp_state_t                 state_q;
   fsp_state_t                 state_d;
   logic [fsp_pkg::CTRL_W-1:0] ctrl_q;
   logic [fsp_pkg::CTRL_W-1:0] ctrl_d;
   logic [2:0]                 timer_q;
   logic [2:0]                 timer_d;
   logic                       erase_q;
   logic                       erase_d;
   logic                       write_q;
   logic                       write_d;
   logic [fsp_pkg::PAGE_W-1:0] page_q;
   logic [fsp_pkg::PAGE_W-1:0] page_d;
   logic                       buf_clr;
   logic                       buf_we;
   logic                       any_loaded;
   logic [5:0]                 code;

   // Page field of the pointer
   function automatic logic [fsp_pkg::PAGE_W-1:0] page_of(input logic [fsp_pkg::PTR_W-1:0] p);
      page_of = p[fsp_pkg::PAGE_LSB +: fsp_pkg::PAGE_W];
   endfunction : page_of

   // Word-in-page field of the pointer, byte bit dropped
   function automatic logic [fsp_pkg::WORD_W-1:0] word_of(input logic [fsp_pkg::PTR_W-1:0] p);
      word_of = p[fsp_pkg::WORD_LSB +: fsp_pkg::WORD_W];
   endfunction : word_of

   // Only defined combinations are taken
   function automatic logic code_valid(input logic [5:0] c);
      code_valid = (c == fsp_pkg::CODE_LOAD) || (c == fsp_pkg::CODE_ERASE) ||
                   (c == fsp_pkg::CODE_WRITE) || (c == fsp_pkg::CODE_CLEAR);
   endfunction : code_valid

   assign code = ctrl_q[5:0] & fsp_pkg::CODE_MASK;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer next state
   always_comb
   begin
      state_d = state_q;
      ctrl_d  = ctrl_q;
      timer_d = timer_q;
      erase_d = 1'b0;
      write_d = 1'b0;
      page_d  = page_q;
      buf_clr = 1'b0;
      buf_we  = 1'b0;
      unique case (state_q)
         ST_IDLE:
         begin
            if (link.ctrl_we && code_valid(link.ctrl_wdata[5:0]))
            begin
               ctrl_d  = {2'h0, link.ctrl_wdata[5:0]};
               timer_d = fsp_pkg::ARM_CYCLES;
               state_d = ST_ARMED;
            end
         end
         ST_ARMED:
         begin
            if (link.store_op)
            begin
               unique case (code)
                  fsp_pkg::CODE_ERASE:
                  begin
                     page_d  = page_of(link.ptr);
                     erase_d = 1'b1;
                     state_d = ST_ERASE;
                  end
                  fsp_pkg::CODE_WRITE:
                  begin
                     page_d  = page_of(link.ptr);
                     write_d = 1'b1;
                     state_d = ST_WRITE;
                  end
                  fsp_pkg::CODE_CLEAR:
                  begin
                     buf_clr = 1'b1;
                     ctrl_d  = '0;
                     state_d = ST_IDLE;
                  end
                  default:
                  begin
                     buf_we  = 1'b1;
                     ctrl_d  = '0;
                     state_d = ST_IDLE;
                  end
               endcase
            end
            else if (timer_q == 3'h1)
            begin
               ctrl_d  = '0;
               state_d = ST_IDLE;
            end
            else
            begin
               timer_d = timer_q - 3'h1;
            end
         end
         ST_ERASE:
         begin
            if (flash_done_i)
            begin
               ctrl_d  = '0;
               state_d = ST_IDLE;
            end
         end
         ST_WRITE:
         begin
            if (flash_done_i)
            begin
               buf_clr = 1'b1;
               ctrl_d  = '0;
               state_d = ST_IDLE;
            end
         end
         default:
         begin
            ctrl_d  = '0;
            state_d = ST_IDLE;
         end
      endcase
      // EEPROM write while words are loaded drops them
      if (link.eeprom_wr && any_loaded)
      begin
         buf_clr = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q       <= ST_IDLE;
         ctrl_q        <= '0;
         timer_q       <= 3'h0;
         erase_q       <= 1'b0;
         write_q       <= 1'b0;
         page_q        <= '0;
      end
      else if (ce_i)
      begin
         state_q       <= state_d;
         ctrl_q        <= ctrl_d;
         timer_q       <= timer_d;
         erase_q       <= erase_d;
         write_q       <= write_d;
         page_q        <= page_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Temporary page buffer
   fsp_page_buf u_buf
   (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .ce_i         (ce_i),
      .clr_i        (buf_clr),
      .we_i         (buf_we),
      .widx_i       (word_of(link.ptr)),
      .wdata_i      (link.data_word),
      .ridx_i       (flash_rd_idx_i),
      .rdata_o      (flash_rd_data_o),
      .any_loaded_o (any_loaded)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign flash_erase_o   = erase_q;
   assign flash_write_o   = write_q;
   assign flash_page_o    = page_q;
   assign link.ctrl_rdata = ctrl_q;
   assign link.halt       = (state_q == ST_ERASE) || (state_q == ST_WRITE);
endmodule : fsp_seq_dev

// *** verification/fsp_link_monitor.sv ***
// Checker for the link between the core end and the self-program sequencer.
// Assumes one clock, synchronous active-high reset and ce_i held high.
`timescale 1ns/10ps
module fsp_link_monitor
(
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   input  wire logic                        ctrl_we,
   input  wire logic [fsp_pkg::CTRL_W-1:0]  ctrl_wdata,
   input  wire logic [fsp_pkg::CTRL_W-1:0]  ctrl_rdata,
   input  wire logic                        store_op,
   input  wire logic [fsp_pkg::PTR_W-1:0]   ptr,
   input  wire logic [fsp_pkg::DATA_W-1:0]  data_word,
   input  wire logic                        eeprom_wr,
   input  wire logic                        halt
);
   logic defined;
   logic idle;

   // Command decode and idle state of the device
   assign defined = ctrl_wdata[5:0] inside {fsp_pkg::CODE_LOAD, fsp_pkg::CODE_ERASE,
                                           fsp_pkg::CODE_WRITE, fsp_pkg::CODE_CLEAR};
   assign idle    = (ctrl_rdata == 8'h00) && !halt;

   default clocking mon_cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ////////////////////////////////////////////////////////////////////////////////
   // Arming and the store window
   a_arm_shows_code : assert property (ctrl_we && defined && idle
      |=> ctrl_rdata == ($past(ctrl_wdata) & 8'h3f))
      else $error("control readback does not show the armed code");
   a_undef_ignored : assert property (ctrl_we && !defined && idle
      |=> ctrl_rdata == 8'h00 && !halt)
      else $error("undefined code changed the sequencer");
   a_window_open : assert property (ctrl_we && defined && idle ##1 !store_op [*3]
      |=> ctrl_rdata != 8'h00)
      else $error("store window closed too early");
   a_window_close : assert property (ctrl_we && defined && idle ##1 !store_op [*4]
      |=> ctrl_rdata == 8'h00)
      else $error("store window did not close after four cycles");

   ////////////////////////////////////////////////////////////////////////////////
   // Store outcomes and the core halt
   a_long_op_halts : assert property (store_op && !halt
      && (ctrl_rdata == 8'h03 || ctrl_rdata == 8'h05)
      |=> halt && ctrl_rdata == $past(ctrl_rdata))
      else $error("erase or write store did not halt the core");
   a_load_disarms : assert property (store_op && !halt
      && (ctrl_rdata == 8'h01 || ctrl_rdata == 8'h11)
      |=> ctrl_rdata == 8'h00 && !halt)
      else $error("load or clear store did not disarm");
   a_enable_busy : assert property (halt
      |-> ctrl_rdata == 8'h03 || ctrl_rdata == 8'h05)
      else $error("enable bit dropped while busy");
   a_release_clears : assert property ($fell(halt) |-> ctrl_rdata == 8'h00)
      else $error("halt released with control bits still set");
   a_core_stalled : assert property (halt |-> !ctrl_we && !store_op)
      else $error("core end issued a request while halted");

   // Main scenarios reached
   c_erase : cover property (store_op && ctrl_rdata == 8'h03);
   c_write : cover property (store_op && ctrl_rdata == 8'h05);
   c_clear : cover property (store_op && ctrl_rdata == 8'h11);
   c_expire : cover property (ctrl_we && defined && idle ##1 !store_op [*4]);
   c_eeprom : cover property (eeprom_wr);
endmodule : fsp_link_monitor

// *** verification/tb_flash_self_program_sequencer.sv ***
// Testbench for both ends of the flash self-program link, with a flash array model.
// Assumes the core end is reached over classic Wishbone at 250 MHz.
`timescale 1ns/10ps
module tb_flash_self_program_sequencer;
   typedef struct packed {logic [15:0] ptr; logic [15:0] data; logic [5:0] idx;} fsp_row_t;

   logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat_w, wb_dat_r, rdv;
   logic        flash_erase, flash_write, flash_done, busy_rd, is_wr;
   logic [6:0]  flash_page, wr_page;
   logic [5:0]  rd_idx;
   logic [15:0] rd_data;
   logic [15:0] mem [128][64];
   int          failures, num_checks, n_erase, n_write, cnt;
   // Scattered word order, pointer bit zero and upper bits set on some rows
   fsp_row_t    rows [5] = '{'{16'h007f, 16'hbeef, 6'h3f}, '{16'h0000, 16'h1357, 6'h00},
                             '{16'h0015, 16'h2468, 6'h0a}, '{16'h0042, 16'h0f1e, 6'h21},
                             '{16'hff2c, 16'h7001, 6'h16}};
   logic [5:0]  undef [5] = '{6'h00, 6'h02, 6'h07, 6'h13, 6'h3f};

   fsp_if fsp_if_inst ();
   fsp_seq_dev fsp_seq_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .link(fsp_if_inst),
      .flash_erase_o(flash_erase), .flash_write_o(flash_write), .flash_page_o(flash_page),
      .flash_done_i(flash_done), .flash_rd_idx_i(rd_idx), .flash_rd_data_o(rd_data));
   fsp_core_end fsp_core_end_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .link(fsp_if_inst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
      .wb_ack_o(wb_ack));
   fsp_link_monitor fsp_link_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
      .ctrl_we(fsp_if_inst.ctrl_we), .ctrl_wdata(fsp_if_inst.ctrl_wdata),
      .ctrl_rdata(fsp_if_inst.ctrl_rdata), .store_op(fsp_if_inst.store_op),
      .ptr(fsp_if_inst.ptr), .data_word(fsp_if_inst.data_word),
      .eeprom_wr(fsp_if_inst.eeprom_wr), .halt(fsp_if_inst.halt));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and watchdog
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial
   begin
      repeat (20000) @(posedge clk_i);
      failures++;
      $display("FAIL watchdog expected finish seen timeout");
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic stop_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n = 0;
      @(posedge clk_i);
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= we;
      wb_adr   <= adr;
      wb_dat_w <= dat;
      while (wb_ack !== 1'b1 && n < 400)
      begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 400)
         chk("wishbone ack", 1, 0);
      rdv = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb_xfer

   // Pointer, data, command, then a status read that stalls while halted;
   // after a command that stores, the core end still shows busy in the cycle that read is taken
   task automatic op(input logic [15:0] ptr, input logic [15:0] data, input logic [31:0] cmd);
      wb_xfer(1'b1, fsp_pkg::ADR_PTR, {16'h0000, ptr});
      wb_xfer(1'b1, fsp_pkg::ADR_DATA, {16'h0000, data});
      wb_xfer(1'b1, fsp_pkg::ADR_CMD, cmd);
      wb_xfer(1'b0, fsp_pkg::ADR_STATUS, 32'h0);
      if (!cmd[fsp_pkg::CMD_NOSTORE])
         chk("status after command", 32'h1, rdv);
   endtask : op

   task automatic chk_buf(input logic [5:0] idx, input logic [15:0] exp, input string what);
      @(posedge clk_i);
      rd_idx <= idx;
      repeat (2) @(posedge clk_i);
      chk(what, {16'h0000, exp}, {16'h0000, rd_data});
   endtask : chk_buf

   ////////////////////////////////////////////////////////////////////////////////
   // Flash array model: erase sets words, write reads the buffer and clears bits
   always @(posedge clk_i)
   begin
      flash_done <= 1'b0;
      if (flash_erase === 1'b1 || flash_write === 1'b1)
      begin
         chk("halt at start", 1, fsp_if_inst.halt);
         n_erase += (flash_erase === 1'b1);
         n_write += (flash_write === 1'b1);
         cnt     <= 0;
         busy_rd <= 1'b1;
         is_wr   <= flash_write;
         wr_page <= flash_page;
      end
      else if (busy_rd)
      begin
         cnt    <= cnt + 1;
         rd_idx <= cnt[5:0];
         if (is_wr && cnt >= 2)
            mem[wr_page][cnt-2] <= mem[wr_page][cnt-2] & rd_data;
         if (!is_wr && cnt < 64)
            mem[wr_page][cnt] <= fsp_pkg::ERASED_WORD;
         if (cnt == 65)
         begin
            chk("halt at done", 1, fsp_if_inst.halt);
            flash_done <= 1'b1;
            busy_rd    <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} = {1'b1, 3'h0, 8'h00, 4'hf, 32'h0};
      {flash_done, busy_rd, is_wr, wr_page, rd_idx, cnt} = '0;
      for (int p = 0; p < 128; p++)
         for (int w = 0; w < 64; w++)
            mem[p][w] = 16'h0000;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb_xfer(1'b0, fsp_pkg::ADR_STATUS, 32'h0);
      chk("status after reset", 32'h0, rdv);
      chk_buf(6'h00, fsp_pkg::ERASED_WORD, "buffer after reset");
      // Table of loads, then erase and write of page 5
      foreach (rows[i])
         op(rows[i].ptr, rows[i].data, {26'h0, fsp_pkg::CODE_LOAD});
      foreach (rows[i])
         chk_buf(rows[i].idx, rows[i].data, "loaded word");
      op(16'hc2bf, 16'h1234, {26'h0, fsp_pkg::CODE_ERASE});
      chk("erase count", 1, n_erase);
      chk("erase page", 5, wr_page);
      op(16'h0280, 16'h5555, {26'h0, fsp_pkg::CODE_WRITE});
      chk("write page", 5, wr_page);
      foreach (rows[i])
         chk("flash word", rows[i].data, mem[5][rows[i].idx]);
      chk("unloaded flash word", fsp_pkg::ERASED_WORD, mem[5][6'h3e]);
      chk_buf(rows[0].idx, fsp_pkg::ERASED_WORD, "buffer after write");
      // Fill between erase and write, last page and last word
      op(16'h3f80, 16'h0000, {26'h0, fsp_pkg::CODE_ERASE});
      op(16'h007e, 16'ha5c3, {26'h0, fsp_pkg::CODE_LOAD});
      op(16'h3f80, 16'h0000, {26'h0, fsp_pkg::CODE_WRITE});
      chk("last word", 16'ha5c3, mem[127][63]);
      chk("first word", fsp_pkg::ERASED_WORD, mem[127][0]);
      // Clear-buffer command and EEPROM write both wipe a loaded word
      op(16'h0004, 16'h0f0f, {26'h0, fsp_pkg::CODE_LOAD});
      chk_buf(6'h02, 16'h0f0f, "word before clear");
      op(16'h0004, 16'h0000, {26'h0, fsp_pkg::CODE_CLEAR});
      chk_buf(6'h02, fsp_pkg::ERASED_WORD, "word after clear");
      op(16'h0006, 16'h3c3c, {26'h0, fsp_pkg::CODE_LOAD});
      chk_buf(6'h03, 16'h3c3c, "word before eeprom write");
      wb_xfer(1'b1, fsp_pkg::ADR_EEWR, 32'h1);
      chk_buf(6'h03, fsp_pkg::ERASED_WORD, "word after eeprom write");
      // Control write with no store lets the window lapse
      op(16'h0008, 16'h7777, 32'h100 | {26'h0, fsp_pkg::CODE_LOAD});
      repeat (6) @(posedge clk_i);
      wb_xfer(1'b0, fsp_pkg::ADR_STATUS, 32'h0);
      chk("status after lapse", 32'h0, rdv);
      chk_buf(6'h04, fsp_pkg::ERASED_WORD, "word after lapse");
      // Undefined codes do nothing
      foreach (undef[i])
         op(16'h000a, 16'h9999, {26'h0, undef[i]});
      chk_buf(6'h05, fsp_pkg::ERASED_WORD, "word after undefined codes");
      chk("op counts", 32'h00020002, {n_erase[15:0], n_write[15:0]});
      // Unmapped address reads zero
      wb_xfer(1'b1, 8'h14, 32'hffffffff);
      wb_xfer(1'b0, 8'h14, 32'h0);
      chk("unmapped read", 32'h0, rdv);
      // Reset in mid-run wipes the buffer
      op(16'h000c, 16'h6060, {26'h0, fsp_pkg::CODE_LOAD});
      chk_buf(6'h06, 16'h6060, "word before reset");
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk_buf(6'h06, fsp_pkg::ERASED_WORD, "word after reset");
      stop_test();
   end
endmodule : tb_flash_self_program_sequencer
